// File: hw/cfg_regs_pkg.sv
// Purpose: Shared constants for the serial configuration and identification registers
// Assumes: 16-bit instruction phase (read flag then 15-bit address), bytes sent MSB first
// Notes:   Widths, offsets, bit positions, reset values and state encodings only; no logic
package cfg_regs_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_BITS  = 15;
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned BYTE_BITS  = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [14:0] OFS_INTERFACE_CONTROL_A = 15'h0000;
  localparam logic [14:0] OFS_INTERFACE_CONTROL_B = 15'h0001;
  localparam logic [14:0] OFS_POWER_CONTROL       = 15'h0002;
  localparam logic [14:0] OFS_PART_CLASS_ID       = 15'h0003;
  localparam logic [14:0] OFS_PART_NUMBER_LOW     = 15'h0004;
  localparam logic [14:0] OFS_PART_NUMBER_HIGH    = 15'h0005;
  localparam logic [14:0] OFS_GRADE_REVISION_ID   = 15'h0006;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RESET_KEY_HIGH          = 7;
  localparam int unsigned BIT_ADDR_ASCENDING          = 5;
  localparam int unsigned BIT_SEPARATE_OUTPUT_ENABLE  = 4;
  localparam int unsigned BIT_RESET_KEY_LOW           = 0;
  localparam int unsigned BIT_TRANSFER_BURST_SELECT   = 7;
  localparam int unsigned POWER_FIELD_LSB             = 0;

  // ----------------------------------------------------------------
  // Values after reset and power state encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INTERFACE_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_INTERFACE_CONTROL_B = 8'h00;
  localparam logic [7:0] POWER_CONTROL_FIXED     = 8'hF0;
  localparam logic [1:0] POWER_STATE_NORMAL      = 2'b00;
  localparam logic [1:0] POWER_STATE_DOWN        = 2'b11;

  // ----------------------------------------------------------------
  // Frame states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_HOLD  = 4'b1000
  } frame_state_t;

endpackage : cfg_regs_pkg

// File: hw/pin_sync.sv
// Purpose: Two-flop synchroniser bank for pins from outside the system clock domain
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Elaboration-time refusal of an empty bank
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : pin_sync

// File: hw/serial_config_id_registers.sv
// Purpose: Serial configuration bus slave with control and identification registers
// Assumes: Bus pins are sampled by clk_sys_in, bus clock idles low, data sampled on its rising edge
// Notes:   Read data changes right after each rising bus clock edge
// Function
// - A software reset starts only when one write sets both reset key bits 7 and 0 of interface control A.
// - A software reset returns all registers to defaults except the address direction and separate output bits.
// - In multibyte transfers bit 5 steps the address down by one when 0 and up by one when 1.
// - With the separate output bit at 0 data in and out share one pin and the dedicated output stays undriven.
// - With the separate output bit at 1 read data leaves on the dedicated output, or lane 0 when rerouted.
// - With the burst select bit 7 of interface control B at 0 multibyte transfers step the address per byte.
// - With the burst select bit at 1 each transaction carries one data byte only.
// - Power state 00 is normal and 11 is power-down, acting exactly like the power-down pin driven high.
// - Power control at 0x02 resets to 0xF0 with read-only upper bits and the power field at normal.
// - The 16-bit part number reads as low byte at 0x04 and high byte at 0x05.
// - Part class is read-only in bits 3:0 at 0x03 with its upper four bits reserved.
// - Address 0x06 holds a read-only silicon revision in bits 3:0.
// - Bits 7:4 of address 0x06 hold a read-only performance grade.
`timescale 1ns/1ns
module serial_config_id_registers
  import cfg_regs_pkg::*;
#(
  parameter logic [3:0]  PART_CLASS  = 4'h1,      // Arbitrary value
  parameter logic [15:0] PART_NUMBER = 16'h1A2B,  // Arbitrary value
  parameter logic [3:0]  GRADE       = 4'h2,      // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h1       // Arbitrary value
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // Serial bus pins
  input  wire logic chip_select_n_in,
  input  wire logic serial_clock_in,
  input  wire logic shared_serial_io_in,
  output logic      shared_serial_io_out,
  output logic      shared_serial_io_oe_out,
  output logic      dedicated_serial_out_out,
  output logic      dedicated_serial_out_oe_out,
  output logic      lane0_data_out_out,
  output logic      lane0_data_out_oe_out,
  // Device controls
  input  wire logic output_reroute_select_in,
  input  wire logic powerdown_pin_in,
  output logic      powerdown_out,
  output logic      soft_reset_pulse_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_sync;

  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   ({chip_select_n_in, serial_clock_in, shared_serial_io_in,
                  output_reroute_select_in, powerdown_pin_in}),
    .sync_out   (pins_sync)
  );

  wire cs_n_s    = pins_sync[4];
  wire sclk_s    = pins_sync[3];
  wire sdi_s     = pins_sync[2];
  wire reroute_s = pins_sync[1];
  wire pd_pin_s  = pins_sync[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                 sclk_prev;
  frame_state_t         state;
  logic [4:0]           bit_count;
  logic [INSTR_BITS-1:0] instr_shift;
  logic                 is_read;
  logic [ADDR_BITS-1:0] addr;
  logic [7:0]           rx_shift;
  logic [7:0]           tx_shift;
  logic                 addr_ascending;
  logic                 separate_output_enable;
  logic                 transfer_burst_select;
  logic [1:0]           power_state_field;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [ADDR_BITS-1:0] a);
    case (a)
      OFS_INTERFACE_CONTROL_A: begin
        read_reg = 8'h00;
        read_reg[BIT_ADDR_ASCENDING]         = addr_ascending;
        read_reg[BIT_SEPARATE_OUTPUT_ENABLE] = separate_output_enable;
      end
      OFS_INTERFACE_CONTROL_B: begin
        read_reg = 8'h00;
        read_reg[BIT_TRANSFER_BURST_SELECT] = transfer_burst_select;
      end
      OFS_POWER_CONTROL:     read_reg = POWER_CONTROL_FIXED | {6'h00, power_state_field};
      OFS_PART_CLASS_ID:     read_reg = {4'h0, PART_CLASS};
      OFS_PART_NUMBER_LOW:   read_reg = PART_NUMBER[7:0];
      OFS_PART_NUMBER_HIGH:  read_reg = PART_NUMBER[15:8];
      OFS_GRADE_REVISION_ID: read_reg = {GRADE, REVISION};
      default:               read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  wire        sclk_rise   = sclk_s && !sclk_prev;
  wire        frame_on    = !cs_n_s;
  wire [15:0] instr_next  = {instr_shift[INSTR_BITS-2:0], sdi_s};
  wire [7:0]  byte_next   = {rx_shift[6:0], sdi_s};
  wire        instr_done  = (state == ST_INSTR) && sclk_rise && (bit_count == 5'd15);
  wire        byte_done   = (state == ST_DATA) && sclk_rise && (bit_count == 5'd7);
  wire        wr_commit   = byte_done && !is_read;

  // Address stepping per data byte
  wire [ADDR_BITS-1:0] addr_stepped = addr_ascending ? addr + 15'd1 : addr - 15'd1;

  // Key bits act only when both are set in the same written byte
  wire        wr_ctrl_a   = wr_commit && (addr == OFS_INTERFACE_CONTROL_A);
  wire        soft_reset  = wr_ctrl_a && byte_next[BIT_RESET_KEY_HIGH] && byte_next[BIT_RESET_KEY_LOW];
  wire        wr_ctrl_b   = wr_commit && (addr == OFS_INTERFACE_CONTROL_B);
  wire        wr_power    = wr_commit && (addr == OFS_POWER_CONTROL);

  // Read data path selection and power-down request
  wire        driving     = frame_on && is_read && (state == ST_DATA);
  wire        use_shared  = driving && !separate_output_enable;
  wire        use_dedic   = driving && separate_output_enable && !reroute_s;
  wire        use_lane0   = driving && separate_output_enable && reroute_s;
  wire        power_down  = pd_pin_s || (power_state_field == POWER_STATE_DOWN);

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  frame_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (frame_on) next_state = ST_INSTR;
      ST_INSTR: if (!frame_on) next_state = ST_IDLE;
                else if (instr_done) next_state = ST_DATA;
      ST_DATA:  if (!frame_on) next_state = ST_IDLE;
                else if (byte_done && transfer_burst_select) next_state = ST_HOLD;
      ST_HOLD:  if (!frame_on) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state     <= ST_IDLE;
      sclk_prev <= 1'b0;
    end else begin
      state     <= next_state;
      sclk_prev <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Shift path and address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bit_count   <= 5'd0;
      instr_shift <= '0;
      rx_shift    <= 8'h00;
      tx_shift    <= 8'h00;
      is_read     <= 1'b0;
      addr        <= '0;
    end else if (!frame_on || state == ST_IDLE) begin
      bit_count <= 5'd0;
    end else if (instr_done) begin
      bit_count <= 5'd0;
      is_read   <= instr_next[INSTR_BITS-1];
      addr      <= instr_next[ADDR_BITS-1:0];
      tx_shift  <= read_reg(instr_next[ADDR_BITS-1:0]);
    end else if (byte_done) begin
      bit_count <= 5'd0;
      addr      <= addr_stepped;
      tx_shift  <= read_reg(addr_stepped);
    end else if (sclk_rise && state == ST_INSTR) begin
      bit_count   <= bit_count + 5'd1;
      instr_shift <= instr_next;
    end else if (sclk_rise && state == ST_DATA) begin
      bit_count <= bit_count + 5'd1;
      rx_shift  <= byte_next;
      tx_shift  <= {tx_shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      addr_ascending         <= RST_INTERFACE_CONTROL_A[BIT_ADDR_ASCENDING];
      separate_output_enable <= RST_INTERFACE_CONTROL_A[BIT_SEPARATE_OUTPUT_ENABLE];
      transfer_burst_select  <= RST_INTERFACE_CONTROL_B[BIT_TRANSFER_BURST_SELECT];
      power_state_field      <= POWER_STATE_NORMAL;
    end else if (soft_reset) begin
      // Direction and output-pin bits survive a software reset
      transfer_burst_select <= RST_INTERFACE_CONTROL_B[BIT_TRANSFER_BURST_SELECT];
      power_state_field     <= POWER_STATE_NORMAL;
    end else begin
      if (wr_ctrl_a) begin
        addr_ascending         <= byte_next[BIT_ADDR_ASCENDING];
        separate_output_enable <= byte_next[BIT_SEPARATE_OUTPUT_ENABLE];
      end
      if (wr_ctrl_b) begin
        transfer_burst_select <= byte_next[BIT_TRANSFER_BURST_SELECT];
      end
      if (wr_power) begin
        power_state_field <= byte_next[POWER_FIELD_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  wire next_bit = tx_shift[7];

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      shared_serial_io_out        <= 1'b0;
      shared_serial_io_oe_out     <= 1'b0;
      dedicated_serial_out_out    <= 1'b0;
      dedicated_serial_out_oe_out <= 1'b0;
      lane0_data_out_out          <= 1'b0;
      lane0_data_out_oe_out       <= 1'b0;
      powerdown_out               <= 1'b0;
      soft_reset_pulse_out        <= 1'b0;
    end else begin
      shared_serial_io_out        <= next_bit;
      shared_serial_io_oe_out     <= use_shared;
      dedicated_serial_out_out    <= next_bit;
      dedicated_serial_out_oe_out <= use_dedic;
      lane0_data_out_out          <= next_bit;
      lane0_data_out_oe_out       <= use_lane0;
      powerdown_out               <= power_down;
      soft_reset_pulse_out        <= soft_reset;
    end
  end

endmodule : serial_config_id_registers

// File: testbench/cfg_regs_asserts.sv
// Purpose: Port-level checks for the serial configuration registers
// Assumes: Inputs held static across frames except the bus pins
// Notes:   Bound into every instance of the design
`timescale 1ns/1ns
module cfg_regs_checker (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Serial bus pins
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic shared_serial_io_in,
  input wire logic shared_serial_io_out,
  input wire logic shared_serial_io_oe_out,
  input wire logic dedicated_serial_out_out,
  input wire logic dedicated_serial_out_oe_out,
  input wire logic lane0_data_out_out,
  input wire logic lane0_data_out_oe_out,
  // Device controls
  input wire logic output_reroute_select_in,
  input wire logic powerdown_pin_in,
  input wire logic powerdown_out,
  input wire logic soft_reset_pulse_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence cs_idle_s; chip_select_n_in [*6]; endsequence
  sequence pin_high_s; powerdown_pin_in [*6]; endsequence
  sequence pin_low_s; !powerdown_pin_in [*6]; endsequence
  AST_OE_EXCL: assert property (!(shared_serial_io_oe_out && dedicated_serial_out_oe_out))
    else $error("shared and dedicated outputs driven together");
  AST_DED_LANE: assert property (!(dedicated_serial_out_oe_out && lane0_data_out_oe_out))
    else $error("dedicated and lane 0 outputs driven together");
  AST_LANE_SEL: assert property ($rose(lane0_data_out_oe_out) |-> output_reroute_select_in)
    else $error("lane 0 driven without reroute");
  AST_DED_SEL: assert property ($rose(dedicated_serial_out_oe_out) |-> !output_reroute_select_in)
    else $error("dedicated output driven while rerouted");
  AST_CS_IDLE: assert property (cs_idle_s |-> !(shared_serial_io_oe_out || dedicated_serial_out_oe_out || lane0_data_out_oe_out))
    else $error("output enabled outside a frame");
  AST_PD_PIN: assert property (pin_high_s |-> powerdown_out)
    else $error("power-down pin not followed");
  AST_PD_FIELD: assert property (pin_low_s ##0 $changed(powerdown_out) |-> !$past(chip_select_n_in, 2))
    else $error("power-down changed with no write");
  AST_SRST_ONE: assert property (soft_reset_pulse_out |=> !soft_reset_pulse_out)
    else $error("soft reset pulse longer than one cycle");
  AST_SRST_FRAME: assert property (soft_reset_pulse_out |-> !$past(chip_select_n_in, 3))
    else $error("soft reset outside a write frame");
  AST_SRST_PD: assert property (pin_low_s ##0 soft_reset_pulse_out |-> ##[0:2] !powerdown_out)
    else $error("power field kept over soft reset");
  AST_RESET_OUTS: assert property (disable iff (1'b0) $fell(reset_in) |->
    !(shared_serial_io_oe_out || dedicated_serial_out_oe_out || powerdown_out || soft_reset_pulse_out))
    else $error("outputs active out of reset");
endmodule : cfg_regs_checker
bind serial_config_id_registers cfg_regs_checker cfg_regs_checker_inst (.clk_sys_in, .reset_in,
  .chip_select_n_in, .serial_clock_in, .shared_serial_io_in, .shared_serial_io_out, .shared_serial_io_oe_out,
  .dedicated_serial_out_out, .dedicated_serial_out_oe_out, .lane0_data_out_out, .lane0_data_out_oe_out,
  .output_reroute_select_in, .powerdown_pin_in, .powerdown_out, .soft_reset_pulse_out);

// File: testbench/spi_host_model.sv
// Purpose: Host controller driving whole register frames on the serial bus
// Assumes: Bus clock 800 ns, idles low, stopped between frames
// Notes:   Released shared pin shows a toggling level, not the last value
`timescale 1ns/1ns
module spi_host_model (
  // Clock
  input  wire logic clk_sys_in,
  // Device side of the bus
  input  wire logic dev_sio_in,
  input  wire logic dev_sio_oe_in,
  input  wire logic ded_in,
  input  wire logic ded_oe_in,
  input  wire logic lane0_in,
  input  wire logic lane0_oe_in,
  // Host driven pins
  output logic      chip_select_n_out,
  output logic      serial_clock_out,
  output logic      shared_wire_out
);
  logic host_oe   = 1'b0;
  logic host_bit  = 1'b0;
  logic last_wire = 1'b0;
  initial chip_select_n_out = 1'b1;
  initial serial_clock_out = 1'b0;
  assign shared_wire_out = dev_sio_oe_in ? dev_sio_in : host_oe ? host_bit : ~last_wire;
  always @(posedge clk_sys_in) last_wire <= shared_wire_out;
  // Sel picks the read pin: 0 shared, 1 dedicated, 2 lane 0
  task automatic xfer(input logic rw, input logic [14:0] addr, input int n, input int sel,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [47:0] tx;
    logic        smp;
    tx = {rw, addr, wd << (32 - 8 * n)};
    rd = '0;
    @(posedge clk_sys_in);
    chip_select_n_out <= 1'b0;
    host_oe <= 1'b1;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      repeat (4) @(posedge clk_sys_in);
      serial_clock_out <= 1'b0;
      host_bit <= tx[47 - i];
      host_oe <= !(rw && i >= 16);
      repeat (4) @(posedge clk_sys_in);
      serial_clock_out <= 1'b1;
      smp = (sel == 0) ? shared_wire_out : (sel == 1) ? (ded_oe_in ? ded_in : ~last_wire)
          : (lane0_oe_in ? lane0_in : ~last_wire);
      if (i >= 16) rd = {rd[30:0], smp};
    end
    repeat (4) @(posedge clk_sys_in);
    serial_clock_out <= 1'b0;
    host_oe <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chip_select_n_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
  endtask : xfer
endmodule : spi_host_model

// File: testbench/serial_config_id_registers_bench.sv
// Purpose: Self-checking bench for the configuration and identification registers
// Assumes: Host model drives all frames
// Notes:   Identity parameter values are arbitrary
`timescale 1ns/1ns
module serial_config_id_registers_bench;
  import cfg_regs_pkg::*;
  localparam logic [3:0]  CLS = 4'h5;
  localparam logic [15:0] PN  = 16'hC3D4;
  localparam logic [3:0]  GRD = 4'h9;
  localparam logic [3:0]  REV = 4'h6;
  logic clk_sys_in = 1'b0;
  logic reset_in   = 1'b1;
  logic reroute    = 1'b0;
  logic pd_pin     = 1'b0;
  logic cs_n, sclk, sio, sio_o, sio_oe, ded, ded_oe, ln0, ln0_oe, pd, srst;
  logic [31:0] rd;
  int err_count = 0;
  int n_checks  = 0;
  int pulses    = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (srst === 1'b1) pulses <= pulses + 1;
  serial_config_id_registers #(.PART_CLASS(CLS), .PART_NUMBER(PN), .GRADE(GRD), .REVISION(REV))
    serial_config_id_registers_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .chip_select_n_in(cs_n),
    .serial_clock_in(sclk), .shared_serial_io_in(sio), .shared_serial_io_out(sio_o),
    .shared_serial_io_oe_out(sio_oe), .dedicated_serial_out_out(ded), .dedicated_serial_out_oe_out(ded_oe),
    .lane0_data_out_out(ln0), .lane0_data_out_oe_out(ln0_oe), .output_reroute_select_in(reroute),
    .powerdown_pin_in(pd_pin), .powerdown_out(pd), .soft_reset_pulse_out(srst));
  spi_host_model spi_host_model_inst (.clk_sys_in(clk_sys_in), .dev_sio_in(sio_o), .dev_sio_oe_in(sio_oe),
    .ded_in(ded), .ded_oe_in(ded_oe), .lane0_in(ln0), .lane0_oe_in(ln0_oe), .chip_select_n_out(cs_n),
    .serial_clock_out(sclk), .shared_wire_out(sio));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    spi_host_model_inst.xfer(1'b0, a, n, 0, d, rd);
  endtask : wr
  task automatic rdc(input logic [14:0] a, input int n, input int sel, input logic [31:0] exp, input string what);
    spi_host_model_inst.xfer(1'b1, a, n, sel, 32'h0, rd);
    chk(what, exp, rd);
  endtask : rdc
  task automatic final_report;
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic id_stream_down;
    rdc(OFS_GRADE_REVISION_ID, 4, 0, {GRD, REV, PN, 4'h0, CLS}, "id bytes");
    rdc(OFS_POWER_CONTROL, 3, 0, 32'h00F0_0000, "defaults");
  endtask : id_stream_down
  task automatic power_modes;
    wr(OFS_POWER_CONTROL, 1, 32'hFF);
    rdc(OFS_POWER_CONTROL, 1, 0, 32'hF3, "power rw");
    chk("pd field", 32'h1, {31'h0, pd});
    wr(OFS_POWER_CONTROL, 1, 32'h01);
    chk("pd 01", 32'h0, {31'h0, pd});
    pd_pin <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk("pd pin", 32'h1, {31'h0, pd});
    pd_pin <= 1'b0;
    wr(OFS_GRADE_REVISION_ID, 2, 32'hFFFF);
    rdc(OFS_GRADE_REVISION_ID, 2, 0, {16'h0, GRD, REV, PN[15:8]}, "ro ids");
  endtask : power_modes
  task automatic four_wire_up;
    wr(OFS_INTERFACE_CONTROL_A, 1, 32'h30);
    rdc(OFS_PART_NUMBER_LOW, 2, 1, {16'h0, PN[7:0], PN[15:8]}, "dedicated up");
    reroute <= 1'b1;
    rdc(OFS_PART_NUMBER_LOW, 2, 2, {16'h0, PN[7:0], PN[15:8]}, "lane0 up");
    reroute <= 1'b0;
  endtask : four_wire_up
  task automatic single_byte;
    wr(OFS_INTERFACE_CONTROL_B, 2, 32'h0002);
    rdc(OFS_POWER_CONTROL, 1, 1, 32'hF2, "stream write");
    wr(OFS_INTERFACE_CONTROL_B, 1, 32'h80);
    wr(OFS_INTERFACE_CONTROL_B, 2, 32'h8003);
    rdc(OFS_POWER_CONTROL, 1, 1, 32'hF2, "single write");
    rdc(OFS_INTERFACE_CONTROL_B, 1, 1, 32'h80, "burst sel");
  endtask : single_byte
  task automatic soft_reset;
    wr(OFS_POWER_CONTROL, 1, 32'h03);
    wr(OFS_INTERFACE_CONTROL_A, 1, 32'hB0);
    chk("half key", 32'h0, pulses);
    rdc(OFS_INTERFACE_CONTROL_A, 1, 1, 32'h30, "keys read 0");
    wr(OFS_INTERFACE_CONTROL_A, 1, 32'h81);
    chk("pulses", 32'h1, pulses);
    rdc(OFS_INTERFACE_CONTROL_A, 2, 1, 32'h3000, "kept bits");
    rdc(OFS_POWER_CONTROL, 1, 1, 32'hF0, "power reset");
  endtask : soft_reset
  // Mid-run hardware reset clears direction, output pin and power field
  task automatic hard_reset;
    wr(OFS_POWER_CONTROL, 1, 32'h03);
    chk("pd before reset", 32'h1, {31'h0, pd});
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("pd after reset", 32'h0, {31'h0, pd});
    rdc(OFS_POWER_CONTROL, 3, 0, 32'h00F0_0000, "hard reset");
  endtask : hard_reset
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    id_stream_down();
    power_modes();
    four_wire_up();
    single_byte();
    soft_reset();
    hard_reset();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_count++;
    final_report();
  end
endmodule : serial_config_id_registers_bench
